// *** rtl/ptwp_pkg.sv ***
// constants and types for the paper tape word field parser
// How it works
// - a word field is start char, eight data chars, stop char; ten total
// - a data position holding neither polarity char nor a start char raises a format error
// - a start char inside an open field drops it and opens a fresh one
// - high polarity char gives a high data pin, low gives low
// - first data char drives bit 7 (msb), then downward to the lsb
// - characters between fields are comments and are ignored
// - characters arrive as 7 or 8 bit ascii; bit 7 is ignored
// - all eight data pins are presented and programmed together
// - a low pin leaves a one, a high pin programs a zero
// - full tape mode programs every location in order, one per field
// - skip mode drops as many fields as locations skipped
// - tape reader and keyboard feed the same field handling
// - first format error stops queueing words; tape errors keep reporting
// - read back each location, retry up to four times, then fail
package ptwp_pkg;
    localparam logic [6:0] CH_START = 7'h42;
    localparam logic [6:0] CH_STOP  = 7'h46;
    localparam logic [6:0] CH_HIGH  = 7'h50;
    localparam logic [6:0] CH_LOW   = 7'h4e;
    localparam int         CLK_MHZ  = 200;
    // pulse and settle widths are board dependent; plain defaults
    localparam int         PGM_NS   = 1000;
    localparam int         READ_NS  = 500;
    localparam int         PGM_CYC  = (PGM_NS * CLK_MHZ + 999) / 1000;
    localparam int         READ_CYC = (READ_NS * CLK_MHZ + 999) / 1000;
    localparam logic [2:0] MAX_RETRY = 3'h4;
    localparam logic [3:0] DATA_CHARS = 4'h8;

    typedef enum logic [1:0] {P_IDLE, P_DATA, P_STOP} ptwp_pst_t;
    typedef enum logic [1:0] {G_IDLE, G_PGM, G_READ, G_FAIL} ptwp_gst_t;

    typedef struct packed {
        logic [7:0] idx;
        logic [7:0] word;
    } ptwp_entry_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
        logic       pgm;
    } ptwp_prom_t;
endpackage

// *** rtl/ptwp_parser.sv ***
// word field parser, word fifo and prom programming sequencer
`timescale 1ns/1ps
`default_nettype none

module ptwp_fifo #(
    parameter int W = 16,
    parameter int D = 4
) (
    // clock and reset
    input  wire logic         ref_clk,
    input  wire logic         reset,
    // fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);
    typedef struct packed {
        logic [AW-1:0] rp;
        logic [AW-1:0] wp;
        logic [AW:0]   cnt;
    } ptwp_fstate_t;

    ptwp_fstate_t       s;
    ptwp_fstate_t       next_s;
    logic [W-1:0]       mem [D];
    logic               wr;
    logic               rd;

    assign in_ready  = (s.cnt != (AW+1)'(D));
    assign out_valid = (s.cnt != '0);
    assign out_data  = mem[s.rp];
    assign wr        = in_valid && in_ready;
    assign rd        = out_valid && out_ready;

    always_comb begin
        next_s = s;
        if (wr) begin
            next_s.wp = (s.wp == AW'(D-1)) ? '0 : s.wp + 1'b1;
        end
        if (rd) begin
            next_s.rp = (s.rp == AW'(D-1)) ? '0 : s.rp + 1'b1;
        end
        next_s.cnt = s.cnt + (AW+1)'(wr) - (AW+1)'(rd);
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // storage has no reset; only the cnt entries from rp onward are ever read
    always_ff @(posedge ref_clk) begin
        if (wr) begin
            mem[s.wp] <= in_data;
        end
    end
endmodule

module ptwp_parser (
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              reset,
    // character sources
    input  wire logic              auto_mode,
    input  wire logic              tape_valid,
    input  wire logic [7:0]        tape_char,
    input  wire logic              key_valid,
    input  wire logic [7:0]        key_char,
    output logic                   char_ready,
    // command
    input  wire logic              start,
    input  wire logic              skip_mode,
    input  wire logic [7:0]        first_addr,
    input  wire logic [7:0]        last_addr,
    // prom side
    output ptwp_pkg::ptwp_prom_t   prom,
    input  wire logic [7:0]        prom_rdata,
    // status
    output logic                   busy,
    output logic                   done,
    output logic                   fail,
    output logic                   retry,
    output logic                   fmt_err,
    output logic [7:0]             err_addr
);
    typedef struct packed {
        ptwp_pkg::ptwp_pst_t  pst;
        logic [3:0]           n;
        logic [7:0]           word;
        logic [7:0]           fidx;
        logic                 halted;
        logic                 rdy;
        logic                 push;
        ptwp_pkg::ptwp_entry_t push_e;
        ptwp_pkg::ptwp_gst_t  gst;
        logic [7:0]           first;
        logic [7:0]           last;
        logic [2:0]           tries;
        logic [15:0]          tmr;
        ptwp_pkg::ptwp_prom_t prom;
        logic                 busy;
        logic                 done;
        logic                 fail;
        logic                 retry;
        logic                 fmt_err;
        logic [7:0]           err_addr;
    } ptwp_state_t;

    ptwp_state_t           s;
    ptwp_state_t           next_s;
    logic                  in_ready;
    logic                  out_valid;
    logic                  pop;
    ptwp_pkg::ptwp_entry_t out_e;
    logic                  c_valid;
    logic [6:0]            ch;
    logic                  acc;
    logic                  is_pol;

    // both sources share one parser; only keyboard entry stops taking chars after a format error
    assign c_valid = auto_mode ? tape_valid : key_valid;
    assign ch      = auto_mode ? tape_char[6:0] : key_char[6:0];
    assign acc     = s.rdy && c_valid && s.busy;
    assign is_pol  = (ch == ptwp_pkg::CH_HIGH) || (ch == ptwp_pkg::CH_LOW);
    // words queued ahead of a format error are still programmed
    assign pop     = out_valid && s.gst == ptwp_pkg::G_IDLE && s.busy;

    ptwp_fifo #(.W(16), .D(4)) u_fifo (
        .ref_clk   (ref_clk),
        .reset     (reset),
        .in_valid  (s.push),
        .in_ready  (in_ready),
        .in_data   (s.push_e),
        .out_valid (out_valid),
        .out_ready (pop),
        .out_data  (out_e)
    );

    always_comb begin
        next_s         = s;
        next_s.push    = 1'b0;
        next_s.retry   = 1'b0;
        next_s.fmt_err = 1'b0;
        if (start) begin
            next_s        = '0;
            next_s.busy   = 1'b1;
            next_s.first  = first_addr;
            next_s.last   = last_addr;
            // short tapes start at the first address, full ones at zero
            next_s.fidx   = skip_mode ? 8'h00 : first_addr;
        end else begin
            // parser
            if (acc) begin
                if (ch == ptwp_pkg::CH_START) begin
                    next_s.pst  = ptwp_pkg::P_DATA;
                    next_s.n    = '0;
                    next_s.word = '0;
                end else begin
                    case (s.pst)
                        ptwp_pkg::P_IDLE: begin
                            next_s.pst = ptwp_pkg::P_IDLE;
                        end
                        ptwp_pkg::P_DATA: begin
                            if (is_pol) begin
                                // msb first, shifted up each char
                                next_s.word = {s.word[6:0],
                                    ch == ptwp_pkg::CH_HIGH};
                                next_s.n = s.n + 1'b1;
                                if (s.n == ptwp_pkg::DATA_CHARS - 1'b1) begin
                                    next_s.pst = ptwp_pkg::P_STOP;
                                end
                            end else begin
                                next_s.pst = ptwp_pkg::P_IDLE;
                            end
                        end
                        ptwp_pkg::P_STOP: begin
                            next_s.pst = ptwp_pkg::P_IDLE;
                        end
                        default: begin
                            next_s.pst = ptwp_pkg::P_IDLE;
                        end
                    endcase
                    if (s.pst != ptwp_pkg::P_IDLE) begin
                        if ((s.pst == ptwp_pkg::P_DATA && !is_pol) ||
                            (s.pst == ptwp_pkg::P_STOP &&
                             ch != ptwp_pkg::CH_STOP)) begin
                            // the bad field still uses up its address
                            next_s.fmt_err  = 1'b1;
                            next_s.err_addr = s.fidx;
                            next_s.halted   = 1'b1;
                            next_s.fidx     = s.fidx + 1'b1;
                        end else if (s.pst == ptwp_pkg::P_STOP) begin
                            next_s.fidx   = s.fidx + 1'b1;
                            next_s.push   = !s.halted;
                            next_s.push_e = '{idx: s.fidx, word: s.word};
                        end
                    end
                end
            end
            // keyboard entry stops at the first error, tape keeps listing
            next_s.rdy = in_ready && !next_s.push &&
                         !(next_s.halted && !auto_mode);
            // programmer
            case (s.gst)
                ptwp_pkg::G_IDLE: begin
                    if (pop && out_e.idx >= s.first) begin
                        next_s.prom.addr = out_e.idx;
                        next_s.prom.data = out_e.word;
                        next_s.prom.pgm  = 1'b1;
                        next_s.tmr       = 16'(ptwp_pkg::PGM_CYC - 1);
                        next_s.tries     = '0;
                        next_s.gst       = ptwp_pkg::G_PGM;
                    end
                end
                ptwp_pkg::G_PGM: begin
                    next_s.tmr = s.tmr - 1'b1;
                    if (s.tmr == '0) begin
                        next_s.prom.pgm = 1'b0;
                        next_s.tmr      = 16'(ptwp_pkg::READ_CYC - 1);
                        next_s.gst      = ptwp_pkg::G_READ;
                    end
                end
                ptwp_pkg::G_READ: begin
                    next_s.tmr = s.tmr - 1'b1;
                    if (s.tmr == '0) begin
                        // a high pin programs a zero, so expect the inverse
                        if (prom_rdata == ~s.prom.data) begin
                            next_s.gst = ptwp_pkg::G_IDLE;
                            if (s.prom.addr == s.last) begin
                                next_s.done = 1'b1;
                                next_s.busy = 1'b0;
                            end
                        end else if (s.tries == ptwp_pkg::MAX_RETRY) begin
                            next_s.fail = 1'b1;
                            next_s.busy = 1'b0;
                            next_s.gst  = ptwp_pkg::G_FAIL;
                        end else begin
                            next_s.tries    = s.tries + 1'b1;
                            next_s.retry    = 1'b1;
                            next_s.prom.pgm = 1'b1;
                            next_s.tmr      = 16'(ptwp_pkg::PGM_CYC - 1);
                            next_s.gst      = ptwp_pkg::G_PGM;
                        end
                    end
                end
                ptwp_pkg::G_FAIL: begin
                    next_s.gst = ptwp_pkg::G_FAIL;
                end
                default: begin
                    next_s.gst = ptwp_pkg::G_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign char_ready = s.rdy;
    assign prom       = s.prom;
    assign busy       = s.busy;
    assign done       = s.done;
    assign fail       = s.fail;
    assign retry      = s.retry;
    assign fmt_err    = s.fmt_err;
    assign err_addr   = s.err_addr;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    sequence stop_seen;
        $past(acc && s.pst == ptwp_pkg::P_STOP && ch == ptwp_pkg::CH_STOP);
    endsequence
    sequence pulse_held;
        (s.prom.pgm && $stable(s.prom.data) && $stable(s.prom.addr))[*2];
    endsequence

    a_field_push: assert property (
        s.push |-> stop_seen)
        else $error("word pushed without a closing stop char");
    a_bad_char: assert property (
        acc && !start && s.pst == ptwp_pkg::P_DATA && !is_pol &&
        ch != ptwp_pkg::CH_START |=> s.fmt_err)
        else $error("bad data char not flagged");
    a_start_restart: assert property (
        acc && !start && ch == ptwp_pkg::CH_START
        |=> s.pst == ptwp_pkg::P_DATA && s.n == 4'h0 && s.word == 8'h00)
        else $error("start char did not restart the field");
    a_msb_first: assert property (
        acc && !start && s.pst == ptwp_pkg::P_DATA && s.n == 4'h0 &&
        ch == ptwp_pkg::CH_HIGH |=> s.word[0] ##7 s.n != 4'h8 || s.word[7])
        else $error("first data char not on the msb");
    a_pin_hold: assert property (
        $rose(s.prom.pgm) |=> pulse_held)
        else $error("data pins moved during the program pulse");
    a_halt_push: assert property (
        s.push |-> !$past(s.halted))
        else $error("word queued after a format error");
    a_retry_cap: assert property (
        $rose(s.fail) |-> s.tries == ptwp_pkg::MAX_RETRY && !s.busy)
        else $error("fail without four retries");
    a_skip_drop: assert property (
        pop && out_e.idx < s.first |=> !s.prom.pgm)
        else $error("skipped field was programmed");
    a_addr_step: assert property (
        s.push |-> s.fidx == s.push_e.idx + 8'h01)
        else $error("address did not step after a field");
    a_readback_ok: assert property (
        s.gst == ptwp_pkg::G_READ && s.tmr == 16'h0000 && !start &&
        prom_rdata == ~s.prom.data |=> s.gst == ptwp_pkg::G_IDLE)
        else $error("good readback did not finish the word");
endmodule

`default_nettype wire

// *** tb/ptwp_src.sv ***
// teletype character source model, tape reader or keyboard
`timescale 1ns/1ps
`default_nettype none

module ptwp_src (
    // clock
    input  wire logic       ref_clk,
    // handshake with the parser
    input  wire logic       char_ready,
    input  wire logic       busy,
    input  wire logic       slow,
    output logic            valid,
    output logic [7:0]      chr
);
    logic [7:0] q[$];
    logic       took;

    initial begin
        valid = 1'b0;
        chr   = 8'h00;
        took  = 1'b0;
    end

    // a char is held until the parser takes it, in tape order
    always @(posedge ref_clk) begin
        took <= valid && char_ready && busy;
    end

    // each line is written once per edge: a taken char is replaced at once
    // or the line is released
    always @(negedge ref_clk) begin
        if (took && q.size() > 0) begin
            void'(q.pop_front());
        end
        if (took || !valid) begin
            if (q.size() > 0 && (!slow || $urandom_range(2) == 0)) begin
                valid = 1'b1;
                chr   = q[0];
            end else if (valid) begin
                valid = 1'b0;
                // a released line shows the inverse of the last char
                chr   = ~chr;
            end
        end
    end
endmodule
`default_nettype wire

// *** tb/ptwp_parser_tb.sv ***
// self-checking bench for the tape word field parser
`timescale 1ns/1ps
`default_nettype none

module ptwp_parser_tb;
    logic                 ref_clk = 1'b0;
    logic                 reset = 1'b1;
    logic                 auto_mode = 1'b1;
    logic                 start = 1'b0;
    logic                 skip_mode = 1'b0;
    logic                 slow = 1'b0;
    logic [7:0]           first_addr = 8'h00;
    logic [7:0]           last_addr = 8'h00;
    logic [7:0]           prom_rdata;
    logic                 char_ready, busy, done, fail, retry, fmt_err, sv;
    logic [7:0]           err_addr, sc;
    ptwp_pkg::ptwp_prom_t prom;
    int                   mismatches = 0;
    int                   n_compared = 0;
    int                   n_bad = 0;
    int                   n_retry = 0;
    logic                 cur_bad = 1'b0;
    logic                 pgm_d = 1'b0;
    logic [15:0]          log_q[$], exp_q[$];
    logic [7:0]           err_q[$];

    always #2.5 ref_clk = ~ref_clk;

    ptwp_src u_src (.ref_clk(ref_clk), .char_ready(char_ready), .busy(busy),
                    .slow(slow), .valid(sv), .chr(sc));

    ptwp_parser u_dut (
        .ref_clk(ref_clk), .reset(reset), .auto_mode(auto_mode),
        .tape_valid(auto_mode & sv), .tape_char(sc),
        .key_valid(~auto_mode & sv), .key_char(sc),
        .char_ready(char_ready), .start(start), .skip_mode(skip_mode),
        .first_addr(first_addr), .last_addr(last_addr), .prom(prom),
        .prom_rdata(prom_rdata), .busy(busy), .done(done), .fail(fail),
        .retry(retry), .fmt_err(fmt_err), .err_addr(err_addr));

    // prom model: a high pin programs a zero; bad cells read back wrong
    assign prom_rdata = cur_bad ? prom.data : ~prom.data;

    always @(negedge ref_clk) begin
        if (prom.pgm && !pgm_d) begin
            cur_bad = n_bad > 0;
            if (n_bad > 0) n_bad--;
            if (log_q.size() == 0 || log_q[$] != {prom.addr, prom.data})
                log_q.push_back({prom.addr, prom.data});
        end
        pgm_d = prom.pgm;
        if (retry) n_retry++;
        if (fmt_err) err_q.push_back(err_addr);
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wrap_up();
        if (mismatches == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // kind 0 good, 1 bad data char, 2 data char at the stop place
    task automatic field(input logic [7:0] w, input int kind);
        logic hi;
        hi = $urandom_range(1);
        u_src.q.push_back({hi, ptwp_pkg::CH_START});
        for (int i = 7; i >= 0; i--) begin
            u_src.q.push_back({hi, w[i] ? ptwp_pkg::CH_HIGH
                                        : ptwp_pkg::CH_LOW});
        end
        if (kind == 1) u_src.q[$ - 3] = 8'h58;
        u_src.q.push_back({hi, kind == 2 ? ptwp_pkg::CH_HIGH
                                         : ptwp_pkg::CH_STOP});
    endtask

    // address a tape field should land at
    function automatic int exp_addr(input int i, input logic [7:0] fa,
                                    input logic sk);
        return sk ? i : fa + i;
    endfunction

    task automatic run(input logic [7:0] fa, input logic [7:0] la,
                       input logic sk, input logic au, input int n,
                       input int ba, input int bb, input int nb,
                       input logic [1:0] df, input int rt);
        logic [7:0] w;
        int         a;
        u_src.q.delete();
        log_q.delete();
        exp_q.delete();
        err_q.delete();
        n_retry = 0;
        n_bad = nb;
        auto_mode = au;
        first_addr = fa;
        last_addr = la;
        skip_mode = sk;
        start = 1'b1;
        @(negedge ref_clk);
        start = 1'b0;
        @(negedge ref_clk);
        repeat (25) u_src.q.push_back(8'h7f);
        for (int i = 0; i < n; i++) begin
            w = $urandom;
            if (i % 4 == 0) begin
                u_src.q.push_back(8'h0d);
                u_src.q.push_back(8'h0a);
                u_src.q.push_back(8'h30 + 8'(i % 10));
            end
            if (i == 1) begin
                // an open field dropped by a fresh start char
                u_src.q.push_back({1'b0, ptwp_pkg::CH_START});
                u_src.q.push_back({1'b0, ptwp_pkg::CH_HIGH});
                u_src.q.push_back({1'b0, ptwp_pkg::CH_LOW});
            end
            field(w, i == ba ? 1 : (i == bb ? 2 : 0));
            a = exp_addr(i, fa, sk);
            if (a >= fa && a <= la && (ba < 0 || i < ba))
                exp_q.push_back({8'(a), w});
        end
        repeat (25) u_src.q.push_back(8'h7f);
        for (int k = 0; k < 4000 && done !== 1'b1 && fail !== 1'b1; k++)
            @(negedge ref_clk);
        check({14'h0, done, fail}, {14'h0, df});
        check({15'h0, busy}, {15'h0, df == 2'b00});
        check(16'(n_retry), 16'(rt));
        check(16'(log_q.size()), 16'(exp_q.size()));
        foreach (exp_q[i]) begin
            if (i < log_q.size()) check(log_q[i], exp_q[i]);
        end
        if (ba >= 0) begin
            check(16'(err_q.size()), 16'h2);
            if (err_q.size() == 2) begin
                check({err_q[0], err_q[1]}, {8'(ba), 8'(bb)});
            end
        end
    endtask

    initial begin
        #(5 * 60000);
        mismatches++;
        wrap_up();
    end

    initial begin
        void'($urandom(46199));
        repeat (12) @(posedge ref_clk);
        @(negedge ref_clk);
        reset = 1'b0;
        run(8'h00, 8'h05, 1'b1, 1'b1, 6, -1, -1, 0, 2'b10, 0);
        slow = 1'b1;
        run(8'h03, 8'h06, 1'b1, 1'b1, 7, -1, -1, 0, 2'b10, 0);
        run(8'h0a, 8'h0c, 1'b0, 1'b0, 3, -1, -1, 0, 2'b10, 0);
        slow = 1'b0;
        run(8'h00, 8'h07, 1'b1, 1'b1, 6, 2, 4, 0, 2'b00, 0);
        run(8'h00, 8'h00, 1'b1, 1'b1, 1, -1, -1, 2, 2'b10, 2);
        run(8'h00, 8'h00, 1'b1, 1'b1, 1, -1, -1, 5, 2'b01, 4);
        wrap_up();
    end
endmodule
`default_nettype wire
